//--- core/sdpsq_sequencer.sv
// SD card slot pin function and power sequencer with an APB register port.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
module sdpsq_sequencer #(
    parameter int UNIT_CYCLES = sdpsq_pkg::SDPSQ_UNIT_CYCLES,
    parameter int DATA_LINES  = 4
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic [31:0]                prdata,
    input  wire logic                  card_present,
    output logic                       detect_mode,
    output logic                       detect_dir_out,
    output logic                       detect_mux_en,
    output logic                       detect_pullup_en,
    output logic                       cardio_mode,
    output logic                       cardio_mux_en,
    output logic                       cardio_pullup_en,
    output logic                       cardio_high_drive,
    output logic [DATA_LINES+1:0]      cardio_dir_out,
    output logic [DATA_LINES+1:0]      cardio_level,
    output logic                       power_pin_mode,
    output logic                       power_pin_dir_out,
    output logic                       power_pin_pullup_en,
    output logic                       power_pin_level,
    output logic                       card_cmd_ok
);
    import sdpsq_pkg::*;

    localparam int NL = DATA_LINES + 2;

    // =================================================================
    // APB slave: one wait state, unmapped addresses answer pslverr.
    logic                    apb_acc;
    logic                    wr_ctrl;
    logic                    wr_cfg;
    logic                    pol_r;
    logic                    pol_nxt;
    logic [SDPSQ_WAIT_W-1:0] wait_r;
    logic [SDPSQ_WAIT_W-1:0] wait_nxt;
    logic                    opened_r;
    logic                    opened_nxt;
    logic                    ins_req_r;
    logic                    ins_req_nxt;
    logic                    rem_req_r;
    logic                    rem_req_nxt;
    logic                    pready_r;
    logic                    pslverr_r;
    logic [31:0]             prdata_r;
    logic                    pslverr_nxt;
    logic [31:0]             prdata_nxt;

    sdpsq_state_t st_r;
    sdpsq_state_t st_nxt;

    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
        addr_hit = (a == off);
    endfunction

    assign apb_acc = psel && penable && !pready_r;
    assign wr_ctrl = apb_acc && pwrite && addr_hit(paddr, SDPSQ_CTRL_OFF);
    assign wr_cfg  = apb_acc && pwrite && addr_hit(paddr, SDPSQ_CFG_OFF);

    // Power is considered on from the moment the level is switched until removal turns it off.
    function automatic logic power_on_state(input sdpsq_state_t s);
        power_on_state = (s == SDPSQ_INS3) || (s == SDPSQ_INSWAIT) || (s == SDPSQ_INS4) ||
                         (s == SDPSQ_ACTIVE) || (s == SDPSQ_REM1);
    endfunction

    always_comb begin
        pol_nxt     = pol_r;
        wait_nxt    = wait_r;
        opened_nxt  = opened_r;
        ins_req_nxt = ins_req_r;
        rem_req_nxt = rem_req_r;
        pslverr_nxt = 1'b0;
        prdata_nxt  = 32'h0000_0000;
        if (wr_cfg && st_r == SDPSQ_IDLE) begin
            pol_nxt  = pwdata[SDPSQ_CFG_POL_BIT];
            wait_nxt = pwdata[SDPSQ_CFG_WAIT_LSB +: SDPSQ_WAIT_W];
        end
        if (wr_ctrl) begin
            if (pwdata[SDPSQ_CTRL_OPEN_BIT] && st_r == SDPSQ_IDLE) begin
                opened_nxt = 1'b1;
            end
            if (pwdata[SDPSQ_CTRL_END_BIT] && st_r == SDPSQ_ACTIVE) begin
                opened_nxt = 1'b0;
            end
            if (pwdata[SDPSQ_CTRL_INSERT_BIT]) begin
                ins_req_nxt = 1'b1;
            end
            if (pwdata[SDPSQ_CTRL_REMOVE_BIT]) begin
                rem_req_nxt = 1'b1;
            end
        end
        // Requests are consumed when the sequencer accepts them; acceptance wins here.
        if (st_r == SDPSQ_IDLE && st_nxt == SDPSQ_INS1) begin
            ins_req_nxt = 1'b0;
        end
        if (st_r != SDPSQ_ACTIVE || st_nxt == SDPSQ_REM1) begin
            rem_req_nxt = 1'b0;
        end
        if (st_r != SDPSQ_IDLE) begin
            ins_req_nxt = (st_r == SDPSQ_IDLE) ? ins_req_nxt : 1'b0;
        end
        if (apb_acc) begin
            if (addr_hit(paddr, SDPSQ_CTRL_OFF)) begin
                prdata_nxt = 32'h0000_0000;
            end else if (addr_hit(paddr, SDPSQ_CFG_OFF)) begin
                prdata_nxt[SDPSQ_CFG_POL_BIT] = pol_r;
                prdata_nxt[SDPSQ_CFG_WAIT_LSB +: SDPSQ_WAIT_W] = wait_r;
            end else if (addr_hit(paddr, SDPSQ_STATUS_OFF)) begin
                prdata_nxt[SDPSQ_STAT_STATE_LSB +: 4] = st_r;
                prdata_nxt[SDPSQ_STAT_OPEN_BIT]  = opened_r;
                prdata_nxt[SDPSQ_STAT_READY_BIT] = (st_r == SDPSQ_ACTIVE);
                prdata_nxt[SDPSQ_STAT_PWR_BIT]   = power_on_state(st_r);
                prdata_nxt[SDPSQ_STAT_BUSY_BIT]  = (st_r != SDPSQ_IDLE) &&
                                                   (st_r != SDPSQ_ACTIVE);
            end else begin
                pslverr_nxt = 1'b1;
            end
        end
    end

    // =================================================================
    // Sequencer: one pin control step per state, each applied for one cycle at least.
    logic wait_start;
    logic wait_done;

    always_comb begin
        st_nxt     = st_r;
        wait_start = 1'b0;
        case (st_r)
            SDPSQ_IDLE: begin
                if (ins_req_r && opened_r && card_present) begin
                    st_nxt = SDPSQ_INS1;
                end
            end
            SDPSQ_INS1: begin
                st_nxt = SDPSQ_INS2;
            end
            SDPSQ_INS2: begin
                st_nxt = SDPSQ_INS3;
            end
            SDPSQ_INS3: begin
                wait_start = 1'b1;
                st_nxt     = SDPSQ_INSWAIT;
            end
            SDPSQ_INSWAIT: begin
                if (!card_present) begin
                    st_nxt = SDPSQ_REM1;
                end else if (wait_done) begin
                    st_nxt = SDPSQ_INS4;
                end
            end
            SDPSQ_INS4: begin
                st_nxt = SDPSQ_ACTIVE;
            end
            SDPSQ_ACTIVE: begin
                if (!card_present) begin
                    st_nxt = SDPSQ_REM1;
                end else if (rem_req_r && !opened_r) begin
                    st_nxt = SDPSQ_REM1;
                end
            end
            SDPSQ_REM1: begin
                st_nxt = SDPSQ_REM2;
            end
            SDPSQ_REM2: begin
                wait_start = 1'b1;
                st_nxt     = SDPSQ_REMWAIT;
            end
            SDPSQ_REMWAIT: begin
                if (wait_done) begin
                    st_nxt = SDPSQ_REM3;
                end
            end
            SDPSQ_REM3: begin
                st_nxt = SDPSQ_IDLE;
            end
            default: begin
                st_nxt = SDPSQ_IDLE;
            end
        endcase
    end

    sdpsq_wait_timer #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_wait (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .start   (wait_start),
        .units   (wait_r),
        .done    (wait_done)
    );

    // =================================================================
    // Pin settings derived from the next state so outputs stay registered.
    logic            det_mode_nxt;
    logic            det_mux_nxt;
    logic            io_mode_nxt;
    logic            io_mux_nxt;
    logic            pwr_mode_nxt;
    logic            pwr_dir_nxt;
    logic            pwr_lvl_nxt;
    logic            cmd_ok_nxt;
    logic            det_mode_r;
    logic            det_mux_r;
    logic            io_mode_r;
    logic            io_mux_r;
    logic            pwr_mode_r;
    logic            pwr_dir_r;
    logic            pwr_lvl_r;
    logic            cmd_ok_r;

    always_comb begin
        det_mode_nxt = SDPSQ_MODE_GPIO;
        det_mux_nxt  = 1'b0;
        io_mode_nxt  = SDPSQ_MODE_GPIO;
        io_mux_nxt   = 1'b0;
        pwr_mode_nxt = pwr_mode_r;
        pwr_dir_nxt  = pwr_dir_r;
        pwr_lvl_nxt  = ~pol_r;
        cmd_ok_nxt   = 1'b0;
        case (st_nxt)
            SDPSQ_INS1, SDPSQ_INS2, SDPSQ_INS3, SDPSQ_INSWAIT, SDPSQ_REM1, SDPSQ_REM2,
            SDPSQ_REMWAIT: begin
                det_mode_nxt = SDPSQ_MODE_PERIPH;
                det_mux_nxt  = 1'b1;
            end
            SDPSQ_INS4, SDPSQ_ACTIVE: begin
                det_mode_nxt = SDPSQ_MODE_PERIPH;
                det_mux_nxt  = 1'b1;
                io_mode_nxt  = SDPSQ_MODE_PERIPH;
                io_mux_nxt   = 1'b1;
                cmd_ok_nxt   = (st_nxt == SDPSQ_ACTIVE);
            end
            default: begin
                det_mode_nxt = SDPSQ_MODE_GPIO;
                det_mux_nxt  = 1'b0;
            end
        endcase
        if (st_nxt == SDPSQ_INS2) begin
            pwr_mode_nxt = SDPSQ_MODE_GPIO;
            pwr_dir_nxt  = 1'b1;
        end
        if (power_on_state(st_nxt)) begin
            pwr_lvl_nxt = pol_r;
        end else begin
            pwr_lvl_nxt = ~pol_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r       <= SDPSQ_IDLE;
            pol_r      <= SDPSQ_POL_RST;
            wait_r     <= SDPSQ_WAIT_RST;
            opened_r   <= 1'b0;
            ins_req_r  <= 1'b0;
            rem_req_r  <= 1'b0;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
            prdata_r   <= 32'h0000_0000;
            det_mode_r <= SDPSQ_MODE_GPIO;
            det_mux_r  <= 1'b0;
            io_mode_r  <= SDPSQ_MODE_GPIO;
            io_mux_r   <= 1'b0;
            pwr_mode_r <= SDPSQ_MODE_GPIO;
            pwr_dir_r  <= 1'b0;
            pwr_lvl_r  <= ~SDPSQ_POL_RST;
            cmd_ok_r   <= 1'b0;
        end else if (ce) begin
            st_r       <= st_nxt;
            pol_r      <= pol_nxt;
            wait_r     <= wait_nxt;
            opened_r   <= opened_nxt;
            ins_req_r  <= ins_req_nxt;
            rem_req_r  <= rem_req_nxt;
            pready_r   <= apb_acc;
            pslverr_r  <= pslverr_nxt;
            prdata_r   <= prdata_nxt;
            det_mode_r <= det_mode_nxt;
            det_mux_r  <= det_mux_nxt;
            io_mode_r  <= io_mode_nxt;
            io_mux_r   <= io_mux_nxt;
            pwr_mode_r <= pwr_mode_nxt;
            pwr_dir_r  <= pwr_dir_nxt;
            pwr_lvl_r  <= pwr_lvl_nxt;
            cmd_ok_r   <= cmd_ok_nxt;
        end
    end

    // =================================================================
    // Output mapping; static settings are constants and come from no logic.
    assign pready              = pready_r;
    assign pslverr             = pslverr_r;
    assign prdata              = prdata_r;
    assign detect_mode         = det_mode_r;
    assign detect_mux_en       = det_mux_r;
    assign detect_dir_out      = 1'b0;
    assign detect_pullup_en    = 1'b0;
    assign cardio_mode         = io_mode_r;
    assign cardio_mux_en       = io_mux_r;
    assign cardio_pullup_en    = 1'b0;
    assign cardio_high_drive   = 1'b1;
    assign cardio_dir_out      = {NL{1'b1}};
    assign cardio_level        = {NL{1'b0}};
    assign power_pin_mode      = pwr_mode_r;
    assign power_pin_dir_out   = pwr_dir_r;
    assign power_pin_pullup_en = 1'b0;
    assign power_pin_level     = pwr_lvl_r;
    assign card_cmd_ok         = cmd_ok_r;

endmodule

//--- common/sdpsq_pkg.sv
// Constants, register map and state encoding of the SD slot pin and power sequencer.
// =====================================================================
package sdpsq_pkg;

    // =================================================================
    // Register map (byte addresses).
    localparam logic [11:0] SDPSQ_CTRL_OFF   = 12'h000;
    localparam logic [11:0] SDPSQ_CFG_OFF    = 12'h004;
    localparam logic [11:0] SDPSQ_STATUS_OFF = 12'h008;

    // Control bits (write one to request).
    localparam int SDPSQ_CTRL_INSERT_BIT = 0;
    localparam int SDPSQ_CTRL_REMOVE_BIT = 1;
    localparam int SDPSQ_CTRL_OPEN_BIT   = 2;
    localparam int SDPSQ_CTRL_END_BIT    = 3;

    // Configuration fields.
    localparam int SDPSQ_CFG_POL_BIT     = 0;
    localparam int SDPSQ_CFG_WAIT_LSB    = 8;
    localparam int SDPSQ_WAIT_W          = 16;
    localparam logic       SDPSQ_POL_RST  = 1'b1;
    localparam logic [15:0] SDPSQ_WAIT_RST = 16'h0064;

    // Status fields.
    localparam int SDPSQ_STAT_STATE_LSB  = 0;
    localparam int SDPSQ_STAT_OPEN_BIT   = 4;
    localparam int SDPSQ_STAT_READY_BIT  = 5;
    localparam int SDPSQ_STAT_PWR_BIT    = 6;
    localparam int SDPSQ_STAT_BUSY_BIT   = 7;

    // Timing: one wait unit is 1 ms at a 40 ns clock.
    localparam int SDPSQ_UNIT_US     = 1000;
    localparam int SDPSQ_CLK_NS      = 40;
    localparam int SDPSQ_UNIT_CYCLES = (SDPSQ_UNIT_US * 1000) / SDPSQ_CLK_NS;

    // Pin mux selections.
    localparam logic SDPSQ_MODE_GPIO  = 1'b0;
    localparam logic SDPSQ_MODE_PERIPH = 1'b1;

    typedef enum logic [3:0] {
        SDPSQ_IDLE    = 4'b0000,
        SDPSQ_INS1    = 4'b0001,
        SDPSQ_INS2    = 4'b0011,
        SDPSQ_INS3    = 4'b0010,
        SDPSQ_INSWAIT = 4'b0110,
        SDPSQ_INS4    = 4'b0111,
        SDPSQ_ACTIVE  = 4'b0101,
        SDPSQ_REM1    = 4'b0100,
        SDPSQ_REM2    = 4'b1100,
        SDPSQ_REMWAIT = 4'b1101,
        SDPSQ_REM3    = 4'b1111
    } sdpsq_state_t;

endpackage

//--- core/sdpsq_wait_timer.sv
// Millisecond wait timer used for supply settling after a power change.
`timescale 1ns/1ps
module sdpsq_wait_timer #(
    parameter int UNIT_CYCLES = sdpsq_pkg::SDPSQ_UNIT_CYCLES
) (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            ce,
    input  wire logic                            start,
    input  wire logic [sdpsq_pkg::SDPSQ_WAIT_W-1:0] units,
    output logic                                 done
);
    import sdpsq_pkg::*;

    localparam int PW = $clog2(UNIT_CYCLES + 1);

    logic [PW-1:0]           pre_r;
    logic [PW-1:0]           pre_nxt;
    logic [SDPSQ_WAIT_W-1:0] cnt_r;
    logic [SDPSQ_WAIT_W-1:0] cnt_nxt;
    logic                    run_r;
    logic                    run_nxt;
    logic                    done_r;
    logic                    done_nxt;

    // =================================================================
    // Counts units of UNIT_CYCLES; a zero count finishes after one cycle.
    always_comb begin
        pre_nxt  = pre_r;
        cnt_nxt  = cnt_r;
        run_nxt  = run_r;
        done_nxt = 1'b0;
        if (start) begin
            pre_nxt = PW'(UNIT_CYCLES - 1);
            cnt_nxt = units;
            run_nxt = 1'b1;
        end else if (run_r) begin
            if (cnt_r == '0) begin
                run_nxt  = 1'b0;
                done_nxt = 1'b1;
            end else if (pre_r == '0) begin
                pre_nxt = PW'(UNIT_CYCLES - 1);
                cnt_nxt = cnt_r - 1'b1;
            end else begin
                pre_nxt = pre_r - 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r  <= '0;
            cnt_r  <= '0;
            run_r  <= 1'b0;
            done_r <= 1'b0;
        end else if (ce) begin
            pre_r  <= pre_nxt;
            cnt_r  <= cnt_nxt;
            run_r  <= run_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;

endmodule

//--- verification/sdpsq_card_model.sv
// Behavioural SD card and power switch standing at the far side of the slot pins.
`timescale 1ns/1ps
module sdpsq_card_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic slot_filled,
    input  wire logic polarity,
    input  wire logic power_pin_dir_out,
    input  wire logic power_pin_level,
    input  wire logic cardio_mux_en,
    output logic      card_present,
    output logic      powered,
    output logic      fault
);
    // =================================================================
    // Power switch
    // The switch conducts only while the pin is driven at its enabling level.
    assign powered = power_pin_dir_out && (power_pin_level == polarity);
    // =================================================================
    // Slot and bus guard
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            card_present <= 1'b0;
            fault        <= 1'b0;
        end else begin
            card_present <= slot_filled;
            // Host lines routed onto an unpowered card would back-feed it.
            if (cardio_mux_en && !powered) begin
                fault <= 1'b1;
            end
        end
    end
endmodule

//--- verification/sdpsq_sequencer_sva.sv
// Port-level checker of the SD slot pin and power sequencer.
`timescale 1ns/1ps
module sdpsq_sequencer_sva #(
    parameter int DATA_LINES = 4
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  ce,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  card_present,
    input wire logic                  detect_mux_en,
    input wire logic                  detect_pullup_en,
    input wire logic                  cardio_mode,
    input wire logic                  cardio_mux_en,
    input wire logic                  cardio_pullup_en,
    input wire logic                  cardio_high_drive,
    input wire logic [DATA_LINES+1:0] cardio_dir_out,
    input wire logic [DATA_LINES+1:0] cardio_level,
    input wire logic                  power_pin_dir_out,
    input wire logic                  power_pin_pullup_en,
    input wire logic                  card_cmd_ok
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // =================================================================
    // Bus answer
    sequence access_s;
        ce && psel && penable && !pready;
    endsequence
    sequence answer_s;
        pready ##1 !pready;
    endsequence
    answer_once_a: assert property (access_s |=> answer_s)
        else $error("pready not a single pulse one cycle after access");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // =================================================================
    // Pin settings and step order
    pullups_off_a: assert property (
        !detect_pullup_en && !cardio_pullup_en && !power_pin_pullup_en)
        else $error("internal pull-up enabled");
    gpio_low_drive_a: assert property (
        cardio_high_drive && (&cardio_dir_out) && cardio_level == '0)
        else $error("card lines not high-drive low outputs");
    route_order_a: assert property (
        (cardio_mux_en || card_cmd_ok) |-> detect_mux_en && power_pin_dir_out)
        else $error("card lines routed before earlier steps");
    cmd_after_route_a: assert property (
        $rose(card_cmd_ok) |-> cardio_mux_en && cardio_mode)
        else $error("commands allowed before lines routed");
    cmd_follows_route_a: assert property ($rose(cardio_mux_en) |-> ##[0:2] card_cmd_ok)
        else $error("commands not allowed after routing");
    power_dir_step_a: assert property (
        $rose(power_pin_dir_out) |-> detect_mux_en && !cardio_mux_en)
        else $error("power pin driven out of step");
    detect_kept_a: assert property ($fell(cardio_mux_en) |-> detect_mux_en)
        else $error("detect routing lost before card lines");
    detect_last_a: assert property (
        $fell(detect_mux_en) |-> !cardio_mux_en && !card_cmd_ok)
        else $error("detect returned to GPIO too early");
    pullout_a: assert property (!card_present |-> ##[0:3] !card_cmd_ok)
        else $error("commands still allowed after pull-out");
endmodule

bind sdpsq_sequencer sdpsq_sequencer_sva #(.DATA_LINES(DATA_LINES)) u_sva (
    .pclk, .presetn, .ce, .psel, .penable, .pready, .pslverr, .card_present,
    .detect_mux_en, .detect_pullup_en, .cardio_mode, .cardio_mux_en, .cardio_pullup_en,
    .cardio_high_drive, .cardio_dir_out, .cardio_level, .power_pin_dir_out,
    .power_pin_pullup_en, .card_cmd_ok
);

//--- verification/sdpsq_sequencer_tb.sv
// Self-checking bench for the SD slot pin and power sequencer.
`timescale 1ns/1ps
module sdpsq_sequencer_tb;
    import sdpsq_pkg::*;
    localparam int UNITS  = 4;
    localparam int WAIT_N = 3;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, cfg;
    logic        card_present, slot_filled, pol, powered, fault, card_cmd_ok;
    logic        detect_mode, detect_dir_out, detect_mux_en, detect_pullup_en;
    logic        cardio_mode, cardio_mux_en, cardio_pullup_en, cardio_high_drive;
    logic [5:0]  cardio_dir_out, cardio_level;
    logic        power_pin_mode, power_pin_dir_out, power_pin_pullup_en, power_pin_level;
    int          n_errors, comparisons, cyc;

    sdpsq_sequencer #(.UNIT_CYCLES(UNITS)) DUT (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
        .prdata, .card_present, .detect_mode, .detect_dir_out, .detect_mux_en,
        .detect_pullup_en, .cardio_mode, .cardio_mux_en, .cardio_pullup_en,
        .cardio_high_drive, .cardio_dir_out, .cardio_level, .power_pin_mode,
        .power_pin_dir_out, .power_pin_pullup_en, .power_pin_level, .card_cmd_ok
    );
    sdpsq_card_model u_card (
        .pclk, .presetn, .slot_filled, .polarity(pol), .power_pin_dir_out,
        .power_pin_level, .cardio_mux_en, .card_present, .powered, .fault
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // =================================================================
    // Shared tasks
    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic fail(input string what);
        n_errors++;
        $display("[ERR] %0t %s", $time, what);
        tally_and_finish();
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) fail("no pready");
        rd = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        check(rd & m, x, "register read");
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: pick = detect_mux_en;
            1: pick = power_pin_dir_out;
            2: pick = powered;
            3: pick = cardio_mux_en;
            default: pick = card_cmd_ok;
        endcase
    endfunction
    task automatic wait_for(input int s, input logic v);
        cyc = 0;
        while (pick(s) !== v && cyc < 3000) begin
            @(posedge pclk);
            cyc++;
        end
        if (pick(s) !== v) fail("wait ran out");
    endtask
    // =================================================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        slot_filled = 1'b0;
        pol = 1'b1;
        n_errors = 0;
        comparisons = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({power_pin_level, power_pin_dir_out, detect_mux_en, cardio_mux_en}, 0, "reset");
        rdchk(SDPSQ_CFG_OFF, 32'h00ff_ff01, 32'h0000_6401);
        apb(1'b0, 12'h0fc, 32'h0000_0000);
        check(e, 1'b1, "unmapped address");
        slot_filled <= 1'b1;
        apb(1'b1, SDPSQ_CTRL_OFF, 32'h0000_0001 << SDPSQ_CTRL_INSERT_BIT);
        repeat (20) @(posedge pclk);
        check(detect_mux_en, 1'b0, "insert before open");
        for (int i = 0; i < 2; i++) begin
            cfg = (WAIT_N << SDPSQ_CFG_WAIT_LSB) | (i == 0);
            apb(1'b1, SDPSQ_CFG_OFF, cfg);
            pol <= (i == 0);
            apb(1'b1, SDPSQ_CTRL_OFF, 32'h0000_0001 << SDPSQ_CTRL_INSERT_BIT);
            apb(1'b1, SDPSQ_CTRL_OFF, 32'h0000_0001 << SDPSQ_CTRL_OPEN_BIT);
            wait_for(0, 1'b1);
            // The power pin stays an output once the first insertion has made it one.
            check({cardio_mux_en, powered, power_pin_dir_out}, i == 1, "step one");
            check({detect_mode, detect_dir_out, power_pin_mode}, 3'b100, "modes");
            wait_for(1, 1'b1);
            check(powered, 1'b0, "step two off level");
            wait_for(2, 1'b1);
            check(cardio_mux_en, 1'b0, "step three");
            wait_for(3, 1'b1);
            check(cyc >= WAIT_N * UNITS, 1'b1, "power-on wait");
            wait_for(4, 1'b1);
            rdchk(SDPSQ_STATUS_OFF, 32'h0000_004f, {25'd0, 1'b1, 2'b00, SDPSQ_ACTIVE});
            apb(1'b1, SDPSQ_CFG_OFF, 32'h0000_0000);
            rdchk(SDPSQ_CFG_OFF, 32'h00ff_ff01, cfg);
            if (i == 0) begin
                apb(1'b1, SDPSQ_CTRL_OFF, 32'h0000_0001 << SDPSQ_CTRL_REMOVE_BIT);
                repeat (20) @(posedge pclk);
                check(card_cmd_ok, 1'b1, "remove before end");
                apb(1'b1, SDPSQ_CTRL_OFF, 32'h0000_0001 << SDPSQ_CTRL_REMOVE_BIT);
                // The pending removal request starts the sequence as soon as end lands.
                apb(1'b1, SDPSQ_CTRL_OFF, 32'h0000_0001 << SDPSQ_CTRL_END_BIT);
            end else begin
                slot_filled <= 1'b0;
            end
            wait_for(3, 1'b0);
            check({detect_mux_en, powered}, 2'b11, "removal step one");
            wait_for(2, 1'b0);
            check(power_pin_level, !pol, "power off level");
            wait_for(0, 1'b0);
            check(cyc >= WAIT_N * UNITS, 1'b1, "power-off wait");
            check({detect_mode, cardio_mode}, 0, "final GPIO");
            rdchk(SDPSQ_STATUS_OFF, 32'h0000_004f, {28'd0, SDPSQ_IDLE});
            check(fault, 1'b0, "lines routed to unpowered card");
        end
        tally_and_finish();
    end
endmodule
